// ==== src/dpsd_top.sv ====
/*
 * Dual channel modulator: control and duty registers,
 * prescaled period counter, compare and sigma-delta paths.
 * Assumes src_tick enables and pin_pair_sel come from
 * logic on clk; the register port is the core's SFR bus.
 */
`timescale 1ns/1ps
`default_nettype none
module dpsd_top (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic [3:0] src_tick,
    input  wire logic       pin_pair_sel,
    output logic      [1:0] pair_a_out,
    output logic      [1:0] pair_a_oe,
    output logic      [1:0] pair_b_out,
    output logic      [1:0] pair_b_oe
);
    import dpsd_pkg::*;

    //----------------------------------------------------
    // state
    //----------------------------------------------------
    logic [7:0]  ctl_ff,  nxt_ctl;
    logic [5:0]  pre_ff,  nxt_pre;
    logic [15:0] cnt_ff,  nxt_cnt;
    logic        ph_ff,   nxt_ph;
    logic [7:0]  hold_ff [NCH];
    logic [7:0]  nxt_hold [NCH];
    logic [15:0] pend_ff [NCH];
    logic [15:0] nxt_pend [NCH];
    logic [15:0] act_ff  [NCH];
    logic [15:0] nxt_act [NCH];
    logic [15:0] acc_ff  [NCH];
    logic [15:0] nxt_acc [NCH];
    logic [1:0]  pf_ff,   nxt_pf;
    logic [1:0]  sd_ff,   nxt_sd;
    logic [7:0]  rd_ff,   nxt_rd;
    logic [1:0]  pa_ff,   pa_oe_ff, pb_ff, pb_oe_ff;
    logic [1:0]  nxt_pa,  nxt_pa_oe, nxt_pb, nxt_pb_oe;

    dpsd_mode_t  mode;
    logic [5:0]  pre_lim;
    logic        tick, step, wrap, apply, ctl_wr;
    logic [15:0] top;
    logic [1:0]  wave;
    logic [1:0]  en;

    //----------------------------------------------------
    // mode decode, source, prescale and period end
    //----------------------------------------------------
    always_comb begin
        mode   = dpsd_mode_t'(ctl_ff[MODE_LSB +: 3]);
        ctl_wr = sfr_wr && (sfr_addr == CTRL_ADDR);
        tick   = src_tick[ctl_ff[SRC_LSB +: 2]];
        case (ctl_ff[DIV_LSB +: 2])
            2'h0:    pre_lim = PRE_LIM1;
            2'h1:    pre_lim = PRE_LIM4;
            2'h2:    pre_lim = PRE_LIM16;
            default: pre_lim = PRE_LIM64;
        endcase
        step = tick && (pre_ff == pre_lim);
        case (mode)
            MD_VAR:             top = act_ff[1];
            MD_TWIN8, MD_DUAL8: top = TOP8;
            default:            top = TOP16;
        endcase
        wrap  = step && (cnt_ff == top);
        // sigma-delta modes load fresh duty every step
        apply = (mode == MD_OFF) || (mode == MD_RSVD) ||
                ((mode == MD_SD_NRZ || mode == MD_SD_RZ) ? step : wrap);
    end

    //----------------------------------------------------
    // per channel output waveform
    //----------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_wave
            always_comb begin
                case (mode)
                    MD_VAR:    wave[c] = (c == 1) && (cnt_ff < act_ff[0]);
                    MD_TWIN8:  wave[c] = cnt_ff[7:0] < act_ff[c][15:8];
                    MD_TWIN16: wave[c] = cnt_ff < act_ff[c];
                    MD_DUAL8:  wave[c] = cnt_ff[7:0] < act_ff[c][7:0];
                    MD_SD_NRZ: wave[c] = sd_ff[c];
                    MD_SD_RZ:  wave[c] = sd_ff[c] && !ph_ff;
                    default:   wave[c] = 1'b0;
                endcase
            end
        end
    endgenerate

    //----------------------------------------------------
    // next state of registers, counter and accumulators
    //----------------------------------------------------
    always_comb begin
        logic [16:0] sum;
        logic [7:0]  hi_addr;
        logic [7:0]  lo_addr;
        sum     = 17'h00000;
        hi_addr = D0H_ADDR;
        lo_addr = D0L_ADDR;
        nxt_ctl = ctl_wr ? sfr_wdata : ctl_ff;
        nxt_pre = tick ? (step ? 6'h00 : pre_ff + 6'h01) : pre_ff;
        nxt_cnt = wrap ? 16'h0000 : (step ? cnt_ff + 16'h0001 : cnt_ff);
        nxt_ph  = step ? !ph_ff : ph_ff;
        nxt_pf  = pf_ff;
        nxt_sd  = sd_ff;
        for (int i = 0; i < NCH; i++) begin
            hi_addr     = (i == 0) ? D0H_ADDR : D1H_ADDR;
            lo_addr     = (i == 0) ? D0L_ADDR : D1L_ADDR;
            nxt_hold[i] = hold_ff[i];
            nxt_pend[i] = pend_ff[i];
            nxt_act[i]  = act_ff[i];
            nxt_acc[i]  = acc_ff[i];
            // running value changes only on apply: period end, sigma-delta step, or any cycle when off or reserved
            if (apply && pf_ff[i]) begin
                nxt_act[i] = pend_ff[i];
                nxt_pf[i]  = 1'b0;
            end
            // rz mode accumulates on the first half step
            if (step && !(mode == MD_SD_RZ && ph_ff)) begin
                sum        = {1'b0, acc_ff[i]} + {1'b0, act_ff[i]};
                nxt_acc[i] = sum[15:0];
                nxt_sd[i]  = sum[16];
            end
            if (sfr_wr && sfr_addr == lo_addr) begin
                if (mode == MD_TWIN8 || mode == MD_DUAL8) begin
                    nxt_pend[i][7:0] = sfr_wdata;
                    nxt_pf[i]        = 1'b1;
                end else begin
                    nxt_hold[i] = sfr_wdata;
                end
            end
            // a new write beats the apply in the same cycle
            if (sfr_wr && sfr_addr == hi_addr) begin
                nxt_pend[i] = {sfr_wdata, hold_ff[i]};
                nxt_pf[i]   = 1'b1;
            end
            if (ctl_wr) begin
                nxt_acc[i] = 16'h0000;
                nxt_sd[i]  = 1'b0;
            end
        end
        if (ctl_wr) begin
            nxt_pre = 6'h00;
            nxt_cnt = 16'h0000;
            nxt_ph  = 1'b0;
        end
    end

    //----------------------------------------------------
    // pin steering and register readback
    //----------------------------------------------------
    always_comb begin
        en[0] = !ctl_ff[OFF_BIT] && (mode != MD_OFF) &&
                (mode != MD_VAR) && (mode != MD_RSVD);
        en[1] = (mode != MD_OFF) && (mode != MD_RSVD);
        nxt_pa    = pin_pair_sel ? 2'h0 : (wave & en);
        nxt_pa_oe = pin_pair_sel ? 2'h0 : en;
        nxt_pb    = pin_pair_sel ? (wave & en) : 2'h0;
        nxt_pb_oe = pin_pair_sel ? en : 2'h0;
        case (sfr_addr)
            CTRL_ADDR: nxt_rd = ctl_ff;
            D0H_ADDR:  nxt_rd = act_ff[0][15:8];
            D0L_ADDR:  nxt_rd = act_ff[0][7:0];
            D1H_ADDR:  nxt_rd = act_ff[1][15:8];
            D1L_ADDR:  nxt_rd = act_ff[1][7:0];
            default:   nxt_rd = 8'h00;
        endcase
    end

    //----------------------------------------------------
    // registers
    //----------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctl_ff   <= CTRL_RESET;
            pre_ff   <= 6'h00;
            cnt_ff   <= 16'h0000;
            ph_ff    <= 1'b0;
            pf_ff    <= 2'h0;
            sd_ff    <= 2'h0;
            rd_ff    <= 8'h00;
            pa_ff    <= 2'h0;
            pa_oe_ff <= 2'h0;
            pb_ff    <= 2'h0;
            pb_oe_ff <= 2'h0;
            for (int i = 0; i < NCH; i++) begin
                hold_ff[i] <= 8'h00;
                pend_ff[i] <= DUTY_RESET;
                act_ff[i]  <= DUTY_RESET;
                acc_ff[i]  <= DUTY_RESET;
            end
        end else begin
            ctl_ff   <= nxt_ctl;
            pre_ff   <= nxt_pre;
            cnt_ff   <= nxt_cnt;
            ph_ff    <= nxt_ph;
            pf_ff    <= nxt_pf;
            sd_ff    <= nxt_sd;
            rd_ff    <= nxt_rd;
            pa_ff    <= nxt_pa;
            pa_oe_ff <= nxt_pa_oe;
            pb_ff    <= nxt_pb;
            pb_oe_ff <= nxt_pb_oe;
            for (int i = 0; i < NCH; i++) begin
                hold_ff[i] <= nxt_hold[i];
                pend_ff[i] <= nxt_pend[i];
                act_ff[i]  <= nxt_act[i];
                acc_ff[i]  <= nxt_acc[i];
            end
        end
    end

    assign sfr_rdata  = rd_ff;
    assign pair_a_out = pa_ff;
    assign pair_a_oe  = pa_oe_ff;
    assign pair_b_out = pb_ff;
    assign pair_b_oe  = pb_oe_ff;

    //----------------------------------------------------
    // checks
    //----------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_low0_wr;
        sfr_wr && sfr_addr == D0L_ADDR && mode == MD_TWIN16;
    endsequence
    sequence s_high0_wr;
        sfr_wr && sfr_addr == D0H_ADDR;
    endsequence

    ctl_clears_cnt_a: assert property (
        ctl_wr |=> cnt_ff == 16'h0000 && pre_ff == 6'h00)
        else $error("control write did not clear counter");
    low_held_a: assert property (
        (s_low0_wr and (!pf_ff[0] && !apply))
        |=> act_ff[0] == $past(act_ff[0]) && hold_ff[0] == $past(sfr_wdata))
        else $error("low byte applied early");
    pair_load_a: assert property (
        s_low0_wr ##1 (!sfr_wr) ##1 (s_high0_wr and !ctl_wr)
        |=> pend_ff[0] == {$past(sfr_wdata), $past(sfr_wdata, 3)} && pf_ff[0])
        else $error("high write did not pair with held low");
    hold_until_end_a: assert property (
        pf_ff[0] && !apply && !sfr_wr |=> act_ff[0] == $past(act_ff[0]))
        else $error("duty changed mid period");
    prescale_a: assert property (
        step |-> tick && pre_ff == (6'h01 << (2 * ctl_ff[DIV_LSB +: 2])) - 6'h01)
        else $error("counter step off prescale");
    div64_a: assert property (
        step && ctl_ff[DIV_LSB +: 2] == 2'h3 && !ctl_wr ##1 (tick && !ctl_wr)[*8]
        |-> !step)
        else $error("divide by 64 stepped too soon");
    first_off_a: assert property (
        ctl_ff[OFF_BIT] |=> pa_oe_ff[0] == 1'b0 && pb_oe_ff[0] == 1'b0)
        else $error("first output not released");
    mode_off_a: assert property (
        (mode == MD_OFF || mode == MD_RSVD) |=> pa_oe_ff == 2'h0 && pb_oe_ff == 2'h0)
        else $error("outputs driven in off mode");
    twin16_cmp_a: assert property (
        mode == MD_TWIN16 && !pin_pair_sel && !ctl_wr
        |=> pa_ff[1] == $past(cnt_ff < act_ff[1]))
        else $error("compare output wrong");
    pair_sel_a: assert property (
        pin_pair_sel |=> pa_oe_ff == 2'h0 && pb_oe_ff == $past(en))
        else $error("pin pair steering wrong");
    sd_nrz_a: assert property (
        mode == MD_SD_NRZ && step && !ctl_wr
        |=> sd_ff[0] == $past({1'b0, acc_ff[0]} + {1'b0, act_ff[0]} > 17'h0FFFF))
        else $error("sigma-delta carry wrong");
endmodule
`default_nettype wire

// ==== pkg/dpsd_pkg.sv ====
/*
 * Constants, mode codes and register map of the dual
 * channel pulse-width and sigma-delta modulator.
 * Assumes an 8-bit special function register port on clk.
 */
//--------------------------------------------------------
// Operation
// - Mode 0 disables, 1 gives one variable-period output on the second pin, 2 twin 8-bit, 3 twin 16-bit.
// - Mode 4 is a dual NRZ 16-bit sigma-delta DAC, 5 dual 8-bit, 6 dual RZ 16-bit sigma-delta, 7 reserved.
// - Both sigma-delta modes resolve the full 16-bit duty word.
// - Control bits 3:2 divide the selected source by 1, 4, 16 or 64 before the counter.
// - Control bits 1:0 pick the source clock, code 11 being the 16.777216 MHz VCO.
// - Control bit 7 switches the first output off and releases its pin.
// - Any control write clears the counter and restarts the period.
// - In 16-bit modes the low byte goes first into a hidden holding byte and is not applied.
// - A high byte write moves high and held low together, applied at period end in compare modes, each step in sigma-delta, at once in off or reserved.
// - Four duty bytes set the two duties; a config input picks which pin pair carries them.
//--------------------------------------------------------
package dpsd_pkg;
    // register offsets
    localparam logic [7:0] CTRL_ADDR = 8'hAE;
    localparam logic [7:0] D0H_ADDR  = 8'hB1;
    localparam logic [7:0] D0L_ADDR  = 8'hB2;
    localparam logic [7:0] D1H_ADDR  = 8'hB3;
    localparam logic [7:0] D1L_ADDR  = 8'hB4;
    // control fields and reset values
    localparam int         OFF_BIT    = 7;
    localparam int         MODE_LSB   = 4;
    localparam int         DIV_LSB    = 2;
    localparam int         SRC_LSB    = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] DUTY_RESET = 16'h0000;
    // prescaler terminal counts for /1, /4, /16, /64
    localparam logic [5:0] PRE_LIM1  = 6'h00;
    localparam logic [5:0] PRE_LIM4  = 6'h03;
    localparam logic [5:0] PRE_LIM16 = 6'h0F;
    localparam logic [5:0] PRE_LIM64 = 6'h3F;
    // counter tops
    localparam logic [15:0] TOP8  = 16'h00FF;
    localparam logic [15:0] TOP16 = 16'hFFFF;
    localparam int          NCH   = 2;

    typedef enum logic [2:0] {
        MD_OFF, MD_VAR, MD_TWIN8, MD_TWIN16,
        MD_SD_NRZ, MD_DUAL8, MD_SD_RZ, MD_RSVD
    } dpsd_mode_t;
endpackage

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the dual channel modulator.
 * Assumes dpsd_pkg and dpsd_top compiled first; no partner.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dpsd_pkg::*;
    logic       clk;
    logic       resetn;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [3:0] src_tick;
    logic       pin_pair_sel;
    logic [1:0] pair_a_out;
    logic [1:0] pair_a_oe;
    logic [1:0] pair_b_out;
    logic [1:0] pair_b_oe;
    logic [7:0] rd;
    int         failures;
    int         num_checks;
    int         h0;
    int         h1;

    dpsd_top u_dut (
        .clk          (clk),
        .resetn       (resetn),
        .sfr_addr     (sfr_addr),
        .sfr_wr       (sfr_wr),
        .sfr_wdata    (sfr_wdata),
        .sfr_rdata    (sfr_rdata),
        .src_tick     (src_tick),
        .pin_pair_sel (pin_pair_sel),
        .pair_a_out   (pair_a_out),
        .pair_a_oe    (pair_a_oe),
        .pair_b_out   (pair_b_out),
        .pair_b_oe    (pair_b_oe)
    );

    // 100 MHz clock
    always #5 clk = ~clk;

    //--------------------------------------------------------
    // access and compare tasks
    //--------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe launched at a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask

    // read data is registered one edge after the address
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        @(negedge clk);
        d = sfr_rdata;
    endtask

    task automatic skip(input int n);
        repeat (n) @(negedge clk);
    endtask

    // count high cycles of both pair A outputs
    task automatic count(input int n);
        h0 = 0;
        h1 = 0;
        repeat (n) begin
            @(negedge clk);
            if (pair_a_out[0] === 1'b1) h0++;
            if (pair_a_out[1] === 1'b1) h1++;
        end
    endtask

    task automatic conclude;
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    //--------------------------------------------------------
    // main sequence
    //--------------------------------------------------------
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        src_tick = 4'h1;
        pin_pair_sel = 1'b0;
        failures = 0;
        num_checks = 0;
        repeat (5) @(negedge clk);
        check(16'(pair_a_oe), 16'h0000);
        resetn = 1'b1;
        rd_reg(CTRL_ADDR, rd);
        check(16'(rd), 16'(CTRL_RESET));
        // unmapped place ignores writes and reads zero
        wr(8'hB5, 8'h5A);
        rd_reg(8'hB5, rd);
        check(16'(rd), 16'h0000);
        // duties 0x4000 and 0xC000, applied at once while off
        wr(D0L_ADDR, 8'h00);
        wr(D0H_ADDR, 8'h40);
        wr(D1L_ADDR, 8'h00);
        wr(D1H_ADDR, 8'hC0);
        rd_reg(D0H_ADDR, rd);
        check(16'(rd), 16'h0040);
        wr(CTRL_ADDR, 8'h20);
        rd_reg(CTRL_ADDR, rd);
        check(16'(rd), 16'h0020);
        skip(4);
        count(256);
        check(16'(h0), 16'h0040);
        check(16'(h1), 16'h00C0);
        check(16'(pair_a_oe), 16'h0003);
        // duty change mid-period waits for the period end
        wr(CTRL_ADDR, 8'h20);
        skip(10);
        wr(D0H_ADDR, 8'h08);
        skip(10);
        check(16'(pair_a_out[0]), 16'h0001);
        skip(240);
        count(256);
        check(16'(h0), 16'h0008);
        wr(D0H_ADDR, 8'h40);
        skip(260);
        // control write restarts the period
        wr(CTRL_ADDR, 8'h20);
        skip(100);
        check(16'(pair_a_out[0]), 16'h0000);
        wr(CTRL_ADDR, 8'h20);
        skip(3);
        check(16'(pair_a_out[0]), 16'h0001);
        // every prescale code scales the period by its divisor
        for (int d = 0; d < 4; d++) begin
            wr(CTRL_ADDR, 8'(8'h20 | (d << DIV_LSB)));
            skip(4);
            count(256 << (2 * d));
            check(16'(h0), 16'(64 << (2 * d)));
            check(16'(h1), 16'(192 << (2 * d)));
        end
        // every source code follows its own tick
        for (int s = 0; s < 4; s++) begin
            src_tick = 4'(1 << s);
            wr(CTRL_ADDR, 8'(8'h20 | s));
            skip(4);
            count(256);
            check(16'(h0), 16'h0040);
        end
        wr(CTRL_ADDR, 8'h20);
        skip(4);
        count(256);
        check(16'(h0), 16'h0100);
        src_tick = 4'h1;
        wr(CTRL_ADDR, 8'hA0);
        skip(3);
        check(16'(pair_a_oe), 16'h0002);
        pin_pair_sel = 1'b1;
        wr(CTRL_ADDR, 8'h20);
        skip(3);
        check(16'(pair_b_oe), 16'h0003);
        check(16'(pair_a_oe), 16'h0000);
        check(16'(pair_b_out), 16'h0003);
        pin_pair_sel = 1'b0;
        // sigma-delta, non-return and return to zero
        wr(CTRL_ADDR, 8'h40);
        skip(4);
        count(64);
        check(16'(h0), 16'h0010);
        check(16'(h1), 16'h0030);
        wr(CTRL_ADDR, 8'h60);
        skip(4);
        count(128);
        check(16'(h0), 16'h0010);
        check(16'(h1), 16'h0030);
        wr(D0L_ADDR, 8'h40);
        wr(D0H_ADDR, 8'h40);
        wr(CTRL_ADDR, 8'h40);
        skip(4);
        count(1024);
        check(16'(h0), 16'h0101);
        // dual 8-bit from the low bytes
        wr(CTRL_ADDR, 8'h50);
        wr(D0L_ADDR, 8'h20);
        wr(D1L_ADDR, 8'h30);
        skip(300);
        count(256);
        check(16'(h0), 16'h0020);
        check(16'(h1), 16'h0030);
        // off and reserved drive nothing high
        for (int i = 0; i < 2; i++) begin
            wr(CTRL_ADDR, (i == 0) ? 8'h00 : 8'h70);
            skip(4);
            count(64);
            check(16'(h0 + h1), 16'h0000);
        end
        // twin 16-bit: duties applied while reserved, then held mid-period
        wr(D0L_ADDR, 8'h10);
        wr(D0H_ADDR, 8'h00);
        wr(D1L_ADDR, 8'h20);
        wr(D1H_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h30);
        count(64);
        check(16'(h0), 16'h0010);
        check(16'(h1), 16'h0020);
        wr(D0L_ADDR, 8'h08);
        wr(D0H_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h30);
        count(64);
        check(16'(h0), 16'h0010);
        rd_reg(D0L_ADDR, rd);
        check(16'(rd), 16'h0010);
        wr(CTRL_ADDR, 8'h00);
        rd_reg(D0L_ADDR, rd);
        check(16'(rd), 16'h0008);
        // variable period: top 0x0013, duty 0x0005
        wr(D1L_ADDR, 8'h13);
        wr(D1H_ADDR, 8'h00);
        wr(D0L_ADDR, 8'h05);
        wr(D0H_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h10);
        skip(4);
        count(20);
        check(16'(h1), 16'h0005);
        check(16'(pair_a_oe[0]), 16'h0000);
        wr(D0L_ADDR, 8'h0A);
        rd_reg(D0L_ADDR, rd);
        check(16'(rd), 16'h0005);
        skip(40);
        count(20);
        check(16'(h1), 16'h0005);
        wr(D0H_ADDR, 8'h00);
        skip(45);
        count(20);
        check(16'(h1), 16'h000A);
        conclude();
    end
endmodule
`default_nettype wire
